// [hdl/imsc_pkg.sv]
// Purpose: Shared constants for the input monitor and switch config block
// Assumes: AXI4-Lite, 32-bit data, one register per aligned word
// Notes: Register byte address is four times the register index
package imsc_pkg;
  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;
  localparam int NUM_INPUTS = 14;
  localparam int REF_W = 4;
  localparam int OFFSET_W = 8;

  // Register indices and byte addresses
  localparam logic [7:0] IDX_DIV_LO = 8'h46;
  localparam logic [7:0] IDX_DIV_HI = 8'h47;
  localparam logic [7:0] IDX_CFG = 8'h48;
  localparam logic [7:0] IDX_GEN_LIM = 8'h49;
  localparam logic [7:0] IDX_SEL_LIM = 8'h4A;
  localparam logic [ADDR_W-1:0] ADDR_DIV_LO = {2'h0, IDX_DIV_LO, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_DIV_HI = {2'h0, IDX_DIV_HI, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CFG = {2'h0, IDX_CFG, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_GEN_LIM = {2'h0, IDX_GEN_LIM, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_SEL_LIM = {2'h0, IDX_SEL_LIM, 2'h0};

  // Reset values
  localparam logic [7:0] RST_DIV_LO = 8'hFF;
  localparam logic [6:0] RST_DIV_HI = 7'h3F;
  localparam logic [7:0] RST_CFG = 8'h05;
  localparam logic [7:0] RST_LIM = 8'h23;

  // Configuration bit positions
  localparam int CFG_FMON_CLK = 7;
  localparam int CFG_REF_FAIL_PIN = 6;
  localparam int CFG_ULTRA_FAST = 5;
  localparam int CFG_EXT_SWITCH = 4;
  localparam int CFG_BO_FREEZE = 3;
  localparam int CFG_BO_ENABLE = 2;
  localparam int CFG_SOFT_EN = 1;
  localparam int CFG_HARD_EN = 0;

  // Limit nibble positions
  localparam int LIM_SOFT_LSB = 4;
  localparam int LIM_HARD_LSB = 0;
  localparam int LIM_W = 4;

  // Reference codes, one-based input numbers
  localparam logic [REF_W-1:0] REF_INPUT_THREE = 4'h3;
  localparam logic [REF_W-1:0] REF_INPUT_FOUR = 4'h4;
  localparam logic [REF_W-1:0] REF_INPUT_FIVE = 4'h5;
  localparam logic [REF_W-1:0] REF_INPUT_SIX = 4'h6;

  // Missing cycles at which ultra-fast mode drops the reference
  localparam logic [1:0] UFS_MISS_LIMIT = 2'h2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : imsc_pkg

// [hdl/imsc_top.sv]
// Purpose: Input monitor and reference switch configuration registers
// Assumes: Offsets from frequency monitors in 3.81 ppm steps, signed
// Notes: Register access over AXI4-Lite, one write and one read at a time
// Behaviour
// - Fifteen-bit divider factor; input divided by factor+1
// - Bit 7 picks frequency monitor clock
// - Bit 6 lets failure pin follow status
// - Ultra-fast mode drops reference before three misses
// - External mode, pin high: input three or five
// - External mode, pin low: input four or six
// - External mode bit loaded from pin at reset
// - Auxiliary DPLL selection untouched by external mode
// - Freeze bit suppresses all build-out events
// - Enable bit: build-out on every reference change
// - Slave mode stores enable, reads zero, forces off
// - Bit 1 enables soft limit alarms
// - Bit 0 enables hard limit alarms
// - General upper nibble: soft limit for others
// - General lower nibble: hard limit for others
// - Hard alarm invalidates input; soft does not
// - Selected-reference limits for current main reference
//
// Our own choice: register access over AXI4-Lite.
module imsc_top
  import imsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic switch_select_pin,
  input wire logic master_slave_select_pin,
  input wire logic selected_ref_failed,
  input wire logic [REF_W-1:0] normal_ref_sel,
  input wire logic input_three_prio_nonzero,
  input wire logic input_four_prio_nonzero,
  input wire logic [REF_W-1:0] aux_ref_sel_in,
  input wire logic missing_cycle,
  input wire logic ref_reacquire,
  input wire logic input_transient,
  input wire logic [NUM_INPUTS-1:0][OFFSET_W-1:0] freq_offset,
  input wire logic [NUM_INPUTS-1:0] activity_valid,
  output logic [14:0] prediv_factor,
  output logic [15:0] prediv_ratio,
  output logic freq_monitor_clock_sel,
  output logic ref_fail_pin,
  output logic ultra_fast_switch,
  output logic ref_disqualify,
  output logic [REF_W-1:0] main_ref_sel,
  output logic [REF_W-1:0] aux_ref_sel,
  output logic build_out_event,
  output logic zero_phase_lock,
  output logic [NUM_INPUTS-1:0] soft_alarm,
  output logic [NUM_INPUTS-1:0] hard_alarm,
  output logic [NUM_INPUTS-1:0] input_valid
);
  logic [7:0] div_lo_reg;
  logic [6:0] div_hi_reg;
  logic [7:0] div_lo_stage_reg;
  logic [6:0] div_hi_shadow_reg;
  logic [7:0] cfg_reg;
  logic [7:0] gen_lim_reg;
  logic [7:0] sel_lim_reg;
  logic [ADDR_W-1:0] aw_addr_reg;
  logic aw_full_reg;
  logic [DATA_W-1:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic w_full_reg;
  logic bvalid_reg;
  logic [1:0] bresp_reg;
  logic rvalid_reg;
  logic [1:0] rresp_reg;
  logic [DATA_W-1:0] rdata_reg;
  logic [REF_W-1:0] main_ref_reg;
  logic [REF_W-1:0] main_ref_next;
  logic [REF_W-1:0] aux_ref_reg;
  logic [1:0] miss_cnt_reg;
  logic disq_reg;
  logic bo_event_reg;
  logic ref_fail_reg;
  logic [NUM_INPUTS-1:0] soft_reg;
  logic [NUM_INPUTS-1:0] hard_reg;
  logic [NUM_INPUTS-1:0] valid_reg;
  logic wr_fire;
  logic rd_fire;
  logic wr_lane0;
  logic [7:0] rd_byte;
  logic rd_hit;
  logic wr_hit;
  logic bo_enable_eff;
  logic ref_change;

  // Write side: address and data may arrive in either order
  assign s_axi_awready = !aw_full_reg && !bvalid_reg;
  assign s_axi_wready = !w_full_reg && !bvalid_reg;
  assign wr_fire = aw_full_reg && w_full_reg && !bvalid_reg;
  assign wr_lane0 = w_strb_reg[0];
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp = bresp_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg <= 1'b0;
      aw_addr_reg <= '0;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_full_reg <= 1'b1;
      aw_addr_reg <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_full_reg <= 1'b0;
      w_data_reg <= '0;
      w_strb_reg <= '0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_full_reg <= 1'b1;
      w_data_reg <= s_axi_wdata;
      w_strb_reg <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_full_reg <= 1'b0;
    end
  end

  always_comb begin
    if (aw_addr_reg == ADDR_DIV_LO) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == ADDR_DIV_HI) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == ADDR_CFG) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == ADDR_GEN_LIM) begin
      wr_hit = 1'b1;
    end else if (aw_addr_reg == ADDR_SEL_LIM) begin
      wr_hit = 1'b1;
    end else begin
      wr_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // Low half is staged; the pair takes effect on the high write
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_lo_stage_reg <= RST_DIV_LO;
      div_lo_reg <= RST_DIV_LO;
      div_hi_reg <= RST_DIV_HI;
    end else if (wr_fire && wr_lane0) begin
      if (aw_addr_reg == ADDR_DIV_LO) begin
        div_lo_stage_reg <= w_data_reg[7:0];
      end else if (aw_addr_reg == ADDR_DIV_HI) begin
        div_lo_reg <= div_lo_stage_reg;
        div_hi_reg <= w_data_reg[6:0];
      end
    end
  end

  // Sync reset: the strap is sampled every reset cycle, last one kept
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_reg <= RST_CFG;
      cfg_reg[CFG_EXT_SWITCH] <= switch_select_pin;
    end else if (wr_fire && wr_lane0 && aw_addr_reg == ADDR_CFG) begin
      cfg_reg <= w_data_reg[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      gen_lim_reg <= RST_LIM;
      sel_lim_reg <= RST_LIM;
    end else if (wr_fire && wr_lane0) begin
      if (aw_addr_reg == ADDR_GEN_LIM) begin
        gen_lim_reg <= w_data_reg[7:0];
      end else if (aw_addr_reg == ADDR_SEL_LIM) begin
        sel_lim_reg <= w_data_reg[7:0];
      end
    end
  end

  // Read side
  assign s_axi_arready = !rvalid_reg;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rresp = rresp_reg;
  assign s_axi_rdata = rdata_reg;
  assign bo_enable_eff = cfg_reg[CFG_BO_ENABLE] && master_slave_select_pin;

  always_comb begin
    rd_hit = 1'b1;
    if (s_axi_araddr == ADDR_DIV_LO) begin
      rd_byte = div_lo_reg;
    end else if (s_axi_araddr == ADDR_DIV_HI) begin
      rd_byte = {1'b0, div_hi_shadow_reg};
    end else if (s_axi_araddr == ADDR_CFG) begin
      rd_byte = cfg_reg;
      rd_byte[CFG_BO_ENABLE] = bo_enable_eff;
    end else if (s_axi_araddr == ADDR_GEN_LIM) begin
      rd_byte = gen_lim_reg;
    end else if (s_axi_araddr == ADDR_SEL_LIM) begin
      rd_byte = sel_lim_reg;
    end else begin
      rd_byte = 8'h00;
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg <= RESP_OKAY;
      rdata_reg <= '0;
    end else if (rd_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
      rdata_reg <= {24'h000000, rd_byte};
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // High half captured with the low read so the pair is coherent
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_hi_shadow_reg <= RST_DIV_HI;
    end else if (rd_fire && s_axi_araddr == ADDR_DIV_LO) begin
      div_hi_shadow_reg <= div_hi_reg;
    end
  end

  assign prediv_factor = {div_hi_reg, div_lo_reg};
  // Factors above the documented maximum are passed on unchecked
  assign prediv_ratio = {1'b0, prediv_factor} + 16'h0001;
  assign freq_monitor_clock_sel = cfg_reg[CFG_FMON_CLK];
  assign ultra_fast_switch = cfg_reg[CFG_ULTRA_FAST];
  assign zero_phase_lock = !bo_enable_eff;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_fail_reg <= 1'b0;
    end else begin
      ref_fail_reg <= cfg_reg[CFG_REF_FAIL_PIN] &&
                      selected_ref_failed;
    end
  end
  assign ref_fail_pin = ref_fail_reg;

  // Reference steering for the main DPLL only
  always_comb begin
    if (cfg_reg[CFG_EXT_SWITCH] && switch_select_pin) begin
      main_ref_next = input_three_prio_nonzero ? REF_INPUT_THREE
                                               : REF_INPUT_FIVE;
    end else if (cfg_reg[CFG_EXT_SWITCH]) begin
      main_ref_next = input_four_prio_nonzero ? REF_INPUT_FOUR
                                              : REF_INPUT_SIX;
    end else begin
      main_ref_next = normal_ref_sel;
    end
  end
  assign ref_change = main_ref_next != main_ref_reg;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_ref_reg <= '0;
      aux_ref_reg <= '0;
    end else begin
      main_ref_reg <= main_ref_next;
      aux_ref_reg <= aux_ref_sel_in;
    end
  end
  assign main_ref_sel = main_ref_reg;
  assign aux_ref_sel = aux_ref_reg;

  // Miss count restarts with each new reference
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      miss_cnt_reg <= '0;
      disq_reg <= 1'b0;
    end else if (ref_change) begin
      miss_cnt_reg <= '0;
      disq_reg <= 1'b0;
    end else if (missing_cycle && miss_cnt_reg != UFS_MISS_LIMIT) begin
      miss_cnt_reg <= miss_cnt_reg + 2'h1;
      if (ultra_fast_switch && miss_cnt_reg + 2'h1 == UFS_MISS_LIMIT) begin
        disq_reg <= 1'b1;
      end
    end
  end
  assign ref_disqualify = disq_reg;

  // Freeze wins over both transient and switch build-out
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bo_event_reg <= 1'b0;
    end else begin
      bo_event_reg <= !cfg_reg[CFG_BO_FREEZE] &&
                      ((bo_enable_eff && (ref_change || ref_reacquire)) ||
                       input_transient);
    end
  end
  assign build_out_event = bo_event_reg;

  // Per-input frequency alarms, limit chosen by current reference
  for (genvar i = 0; i < NUM_INPUTS; i++) begin : g_mon
    logic is_sel;
    logic [LIM_W-1:0] soft_lim;
    logic [LIM_W-1:0] hard_lim;
    logic [OFFSET_W-1:0] mag;
    assign is_sel = main_ref_reg == REF_W'(i + 1);
    assign soft_lim = is_sel ? sel_lim_reg[LIM_SOFT_LSB +: LIM_W]
                             : gen_lim_reg[LIM_SOFT_LSB +: LIM_W];
    assign hard_lim = is_sel ? sel_lim_reg[LIM_HARD_LSB +: LIM_W]
                             : gen_lim_reg[LIM_HARD_LSB +: LIM_W];
    // Magnitude of most negative code wraps to 8'h80, read unsigned as 128
    assign mag = freq_offset[i][OFFSET_W-1] ? OFFSET_W'(-freq_offset[i])
                                             : freq_offset[i];
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        soft_reg[i] <= 1'b0;
        hard_reg[i] <= 1'b0;
        valid_reg[i] <= 1'b0;
      end else begin
        soft_reg[i] <= cfg_reg[CFG_SOFT_EN] &&
                       mag > {4'h0, soft_lim} + 8'h01;
        hard_reg[i] <= cfg_reg[CFG_HARD_EN] &&
                       mag > {4'h0, hard_lim} + 8'h01;
        valid_reg[i] <= activity_valid[i] &&
                        !(cfg_reg[CFG_HARD_EN] &&
                          mag > {4'h0, hard_lim} + 8'h01);
      end
    end
  end
  assign soft_alarm = soft_reg;
  assign hard_alarm = hard_reg;
  assign input_valid = valid_reg;
endmodule : imsc_top

// [testbench/imsc_props.sv]
// Purpose: Port-level checks for imsc_top
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to every imsc_top instance
module imsc_props
  import imsc_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [DATA_W-1:0] s_axi_rdata,
  input wire logic selected_ref_failed,
  input wire logic ref_fail_pin,
  input wire logic [14:0] prediv_factor,
  input wire logic [15:0] prediv_ratio,
  input wire logic [REF_W-1:0] aux_ref_sel_in,
  input wire logic [REF_W-1:0] aux_ref_sel,
  input wire logic master_slave_select_pin,
  input wire logic zero_phase_lock,
  input wire logic ultra_fast_switch,
  input wire logic ref_disqualify,
  input wire logic [NUM_INPUTS-1:0] activity_valid,
  input wire logic [NUM_INPUTS-1:0] hard_alarm,
  input wire logic [NUM_INPUTS-1:0] input_valid
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_b_wait;
    s_axi_bvalid && !s_axi_bready;
  endsequence
  a_write_resp_lat: assert property (s_wr_both |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_bresp_stands: assert property (s_b_wait |=> s_axi_bvalid)
    else $error("write response dropped");
  a_read_resp_lat: assert property (s_axi_arvalid && s_axi_arready
    |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0)
    else $error("read response wrong");
  a_rdata_stands: assert property (s_axi_rvalid && !s_axi_rready
    |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data moved");
  a_ratio_plus_one: assert property (
    prediv_ratio == {1'b0, prediv_factor} + 16'h0001)
    else $error("ratio not factor plus one");
  a_fail_pin_gate: assert property (
    ref_fail_pin |-> $past(selected_ref_failed)) else $error("fail pin high");
  a_disq_needs_ufs: assert property (
    $rose(ref_disqualify) |-> $past(ultra_fast_switch))
    else $error("disqualify without ultra-fast mode");
  a_aux_pass_thru: assert property (
    $past(aresetn) |-> aux_ref_sel == $past(aux_ref_sel_in))
    else $error("aux selection altered");
  a_slave_zero_lock: assert property (
    !master_slave_select_pin |-> zero_phase_lock)
    else $error("build-out not forced off");
  a_hard_invalid: assert property (
    (hard_alarm & input_valid) == {NUM_INPUTS{1'b0}})
    else $error("hard alarm input still valid");
  a_valid_active: assert property (
    $past(aresetn) |-> (input_valid & ~$past(activity_valid)) == 14'h0)
    else $error("inactive input valid");
endmodule // imsc_props

bind imsc_top imsc_props imsc_props_i (.aclk, .aresetn, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid,
  .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
  .s_axi_rready, .s_axi_rdata, .selected_ref_failed, .ref_fail_pin,
  .prediv_factor, .prediv_ratio, .aux_ref_sel_in, .aux_ref_sel,
  .master_slave_select_pin, .zero_phase_lock, .ultra_fast_switch,
  .ref_disqualify, .activity_valid, .hard_alarm, .input_valid);

// [testbench/tb.sv]
// Purpose: Self-checking bench for imsc_top
// Assumes: AXI4-Lite master in the bench, responses queued
// Notes: Outputs sampled at the falling edge, responses at the rising edge
`define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin \
  mismatches++; $display("[FAIL] %0t got %0h exp %0h", $time, a, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import imsc_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
  logic [2:0] s_axi_awprot = '0, s_axi_arprot = '0;
  logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic s_axi_arvalid = 0, s_axi_rready = 0;
  logic [DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic switch_select_pin = 1, master_slave_select_pin = 1;
  logic selected_ref_failed = 0, missing_cycle = 0, ref_reacquire = 0;
  logic input_three_prio_nonzero = 1, input_four_prio_nonzero = 1;
  logic input_transient = 0;
  logic [REF_W-1:0] normal_ref_sel = 4'h2, aux_ref_sel_in = 4'h1;
  logic [NUM_INPUTS-1:0][OFFSET_W-1:0] freq_offset = '0, fo;
  logic [NUM_INPUTS-1:0] activity_valid = '1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic s_axi_rvalid, freq_monitor_clock_sel, ref_fail_pin;
  logic ultra_fast_switch, ref_disqualify, build_out_event;
  logic zero_phase_lock;
  logic [1:0] s_axi_bresp, s_axi_rresp, eb;
  logic [14:0] prediv_factor, f;
  logic [15:0] prediv_ratio;
  logic [REF_W-1:0] main_ref_sel, aux_ref_sel, x, ex;
  logic [NUM_INPUTS-1:0] soft_alarm, hard_alarm, input_valid;
  logic [33:0] er;
  logic [1:0] bq[$];
  logic [33:0] rq[$];
  int mismatches = 0, comparisons = 0, bo_n = 0;

  imsc_top imsc_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .switch_select_pin, .master_slave_select_pin,
    .selected_ref_failed, .normal_ref_sel, .input_three_prio_nonzero,
    .input_four_prio_nonzero, .aux_ref_sel_in, .missing_cycle,
    .ref_reacquire, .input_transient, .freq_offset, .activity_valid,
    .prediv_factor, .prediv_ratio, .freq_monitor_clock_sel,
    .ref_fail_pin, .ultra_fast_switch, .ref_disqualify, .main_ref_sel,
    .aux_ref_sel, .build_out_event, .zero_phase_lock, .soft_alarm,
    .hard_alarm, .input_valid);

  always #4 aclk = ~aclk;

  always @(posedge aclk) begin
    if (s_axi_bvalid && s_axi_bready) begin
      eb = bq.pop_front();
      `CHK(s_axi_bresp, eb)
    end
    if (s_axi_rvalid && s_axi_rready) begin
      er = rq.pop_front();
      `CHK({s_axi_rdata, s_axi_rresp}, er)
    end
    if (build_out_event === 1'b1) bo_n++;
  end

  task end_of_test();
    // A response still owed counts against the run
    if (bq.size() != 0 || rq.size() != 0) mismatches++;
    if (mismatches == 0 && comparisons > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task w(input int k);
    repeat (k) @(posedge aclk);
    @(negedge aclk);
  endtask

  task rst(input logic p);
    @(posedge aclk);
    aresetn <= 1'b0;
    switch_select_pin <= p;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask

  task wr(input logic [ADDR_W-1:0] a, input logic [7:0] d,
          input logic [1:0] r);
    bq.push_back(r);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    // No cycle limit here: only the watchdog ends a stuck wait
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask

  task rd(input logic [ADDR_W-1:0] a, input logic [7:0] d,
          input logic [1:0] r);
    rq.push_back({24'h0, d, r});
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    s_axi_rready <= 1'b0;
  endtask

  // Pulses one cycle wide on the named strobe
  task pz(input int k);
    @(posedge aclk);
    if (k == 0) input_transient <= 1'b1;
    else if (k == 1) ref_reacquire <= 1'b1;
    else missing_cycle <= 1'b1;
    @(posedge aclk);
    {input_transient, ref_reacquire, missing_cycle} <= 3'h0;
  endtask

  // Enables as last written to the configuration
  task alarms(input int sel, input logic se, input logic he);
    int o, a;
    logic [7:0] l;
    logic [NUM_INPUTS-1:0] es, eh;
    for (int i = 0; i < NUM_INPUTS; i++) begin
      o = $signed(freq_offset[i]);
      a = (o < 0) ? -o : o;
      l = (i + 1 == sel) ? 8'h45 : 8'h12;
      es[i] = se && a > l[7:4] + 1;
      eh[i] = he && a > l[3:0] + 1;
    end
    `CHK(soft_alarm, es)
    `CHK(hard_alarm, eh)
    `CHK(input_valid, activity_valid & ~eh)
  endtask

  initial begin
    void'($urandom(51934));
    rst(1'b1);
    rd(ADDR_DIV_LO, 8'hFF, RESP_OKAY);
    rd(ADDR_DIV_HI, 8'h3F, RESP_OKAY);
    rd(ADDR_CFG, 8'h15, RESP_OKAY);
    rd(ADDR_GEN_LIM, 8'h23, RESP_OKAY);
    rd(ADDR_SEL_LIM, 8'h23, RESP_OKAY);
    wr(12'h200, 8'h5A, RESP_SLVERR);
    rd(12'h200, 8'h00, RESP_SLVERR);
    for (int k = 0; k < 4; k++) begin
      x = 4'($urandom);
      @(posedge aclk);
      switch_select_pin <= k[1];
      input_three_prio_nonzero <= k[0];
      input_four_prio_nonzero <= k[0];
      aux_ref_sel_in <= x;
      w(3);
      ex = k[1] ? (k[0] ? REF_INPUT_THREE : REF_INPUT_FIVE)
                : (k[0] ? REF_INPUT_FOUR : REF_INPUT_SIX);
      `CHK(main_ref_sel, ex)
      `CHK(aux_ref_sel, x)
    end
    rst(1'b0);
    rd(ADDR_CFG, 8'h05, RESP_OKAY);
    wr(ADDR_DIV_LO, 8'h2F, RESP_OKAY);
    w(1);
    `CHK(prediv_factor, 15'h3FFF)
    for (int k = 0; k < 3; k++) begin
      f = 15'($urandom_range(19439));
      wr(ADDR_DIV_LO, f[7:0], RESP_OKAY);
      wr(ADDR_DIV_HI, {1'b0, f[14:8]}, RESP_OKAY);
      w(1);
      `CHK(prediv_factor, f)
      `CHK(prediv_ratio, {1'b0, f} + 16'h0001)
      rd(ADDR_DIV_LO, f[7:0], RESP_OKAY);
      rd(ADDR_DIV_HI, {1'b0, f[14:8]}, RESP_OKAY);
    end
    wr(ADDR_CFG, 8'hC7, RESP_OKAY);
    @(posedge aclk);
    selected_ref_failed <= 1'b1;
    pz(2);
    pz(2);
    w(2);
    `CHK(freq_monitor_clock_sel, 1'b1)
    `CHK(ref_fail_pin, 1'b1)
    `CHK(ref_disqualify, 1'b0)
    `CHK(ultra_fast_switch, 1'b0)
    wr(ADDR_CFG, 8'h07, RESP_OKAY);
    w(2);
    `CHK(ref_fail_pin, 1'b0)
    `CHK(freq_monitor_clock_sel, 1'b0)
    bo_n = 0;
    pz(1);
    @(posedge aclk);
    normal_ref_sel <= 4'h7;
    w(4);
    `CHK(bo_n, 2)
    `CHK(zero_phase_lock, 1'b0)
    wr(ADDR_CFG, 8'h0F, RESP_OKAY);
    w(1);
    bo_n = 0;
    pz(0);
    pz(1);
    @(posedge aclk);
    normal_ref_sel <= 4'h2;
    w(4);
    `CHK(bo_n, 0)
    wr(ADDR_CFG, 8'h03, RESP_OKAY);
    w(1);
    bo_n = 0;
    pz(0);
    @(posedge aclk);
    normal_ref_sel <= 4'h7;
    w(4);
    `CHK(bo_n, 1)
    `CHK(zero_phase_lock, 1'b1)
    @(posedge aclk);
    master_slave_select_pin <= 1'b0;
    wr(ADDR_CFG, 8'h07, RESP_OKAY);
    rd(ADDR_CFG, 8'h03, RESP_OKAY);
    w(1);
    bo_n = 0;
    @(posedge aclk);
    normal_ref_sel <= 4'h2;
    w(4);
    `CHK(bo_n, 0)
    @(posedge aclk);
    master_slave_select_pin <= 1'b1;
    rd(ADDR_CFG, 8'h07, RESP_OKAY);
    wr(ADDR_CFG, 8'h23, RESP_OKAY);
    pz(2);
    w(2);
    `CHK(ref_disqualify, 1'b0)
    pz(2);
    w(2);
    `CHK(ref_disqualify, 1'b1)
    `CHK(ultra_fast_switch, 1'b1)
    wr(ADDR_GEN_LIM, 8'h12, RESP_OKAY);
    wr(ADDR_SEL_LIM, 8'h45, RESP_OKAY);
    for (int r = 0; r < 5; r++) begin
      if (r == 3) wr(ADDR_CFG, 8'h01, RESP_OKAY);
      if (r == 4) wr(ADDR_CFG, 8'h00, RESP_OKAY);
      for (int i = 0; i < NUM_INPUTS; i++)
        fo[i] = 8'($urandom_range(20)) - 8'h0A;
      if (r == 0) fo[0] = 8'h80;
      @(posedge aclk);
      freq_offset <= fo;
      activity_valid <= 14'($urandom);
      if (r == 2) normal_ref_sel <= 4'h5;
      w(3);
      alarms(int'(normal_ref_sel), r < 3, r < 4);
    end
    end_of_test();
  end

  initial begin
    #100000;
    mismatches++;
    end_of_test();
  end
endmodule // tb
